// ### core/sli_engine.sv
// sli_engine: ten-step configurable sequence engine with input select.
// assumes selector codes are held steady by configuration logic outside;
// status inputs are synchronous levels from the drive control core.
// How it works
// R01: ten steps, each two input selects, logic, timer select, timer value, one output; timer slots are accepted but not used here.
// R02: step codes are five consecutive slots, codes one to fifty.
// R03: step outputs are internal signals only, never settable codes.
// R04: codes 2001..2010 feed from step output number code minus 2000.
// R05: codes 4001..4007 feed digital input terminals one to seven.
// R06: code 4010 feeds forward terminal, 4011 reverse terminal.
// R07: codes 6000..6002 give run commands gated by nonzero frequency.
// R08: codes 6003..6005 give accelerating, decelerating, anti-regen flags.
// R09: code 6006 gives the dancer in-range flag.
// R10: code 6007 gives alarm-factor flag, high when no alarm present.
// R11: whole sequence evaluated once every 2 ms tick.
// R12: mode zero disables the sequence, one enables it.
// R13: logic codes 0 off, 1 through, 2 and, 3 or, 4 xor.
// R14: code plus 1000 selects the inverted form of the same source.
`timescale 1ns/1ps
module sli_engine #(
  // hardware keeps the 2 ms default; a short run may shorten the tick
  parameter int TICK_CYCLES = sli_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic sequence_mode_select,
  // flat config: code index (n-1) at [n*16-1 -: 16]
  input wire logic [sli_pkg::LAST_CODE*sli_pkg::CODE_W-1:0] step_settings,
  input wire logic [sli_pkg::TERM_COUNT-1:0] digital_input_terminals,
  input wire logic forward_run_terminal,
  input wire logic reverse_run_terminal,
  input wire logic frequency_command_nonzero,
  input wire logic run_command,
  input wire logic forward_command,
  input wire logic reverse_command,
  input wire logic accelerating_flag,
  input wire logic decelerating_flag,
  input wire logic anti_regen_active_flag,
  input wire logic dancer_in_range_flag,
  input wire logic alarm_present,
  output logic [sli_pkg::STEP_COUNT-1:0] step_results,
  output logic sequence_tick
);
  logic [31:0] tick_count;
  logic [31:0] next_tick_count;
  logic next_sequence_tick;
  logic [7:0] status_vec;
  logic [7:0] next_status_vec;
  logic enable;
  logic [sli_pkg::STEP_COUNT-1:0] results;

  // ==========================================================
  // processing tick divider
  always_comb begin
    next_tick_count = tick_count + 32'h00000001;
    next_sequence_tick = 1'b0;
    if (tick_count == 32'(TICK_CYCLES - 1)) begin // R11
      next_tick_count = 32'h00000000;
      next_sequence_tick = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tick_count <= 32'h00000000;
      sequence_tick <= 1'b0;
    end else begin
      tick_count <= next_tick_count;
      sequence_tick <= next_sequence_tick;
    end
  end

  // ==========================================================
  // drive status sources, registered
  always_comb begin
    next_status_vec[0] = frequency_command_nonzero & run_command; // R07
    next_status_vec[1] = frequency_command_nonzero & forward_command; // R07
    next_status_vec[2] = frequency_command_nonzero & reverse_command; // R07
    next_status_vec[3] = accelerating_flag; // R08
    next_status_vec[4] = decelerating_flag; // R08
    next_status_vec[5] = anti_regen_active_flag; // R08
    next_status_vec[6] = dancer_in_range_flag; // R09
    // active when no alarm factor is present
    next_status_vec[7] = ~alarm_present; // R10
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      status_vec <= 8'h00;
    end else begin
      status_vec <= next_status_vec;
    end
  end

  assign enable = (sequence_mode_select == sli_pkg::MODE_ENABLE); // R12

  // ==========================================================
  // steps; timer slots are accepted but timers are not modelled here
  // steps read the previous tick's results, so ordering has no loops
  genvar g;
  generate
    for (g = 0; g < sli_pkg::STEP_COUNT; g++) begin : g_step // R01
      localparam int B = g * sli_pkg::CODES_PER_STEP; // R02
      sli_step u_step (
        .core_clk(core_clk),
        .nrst(nrst),
        .tick(sequence_tick),
        .enable(enable),
        .first_input_select(step_settings[(B + sli_pkg::SLOT_IN1) * sli_pkg::CODE_W +:
                                          sli_pkg::CODE_W]),
        .second_input_select(step_settings[(B + sli_pkg::SLOT_IN2) * sli_pkg::CODE_W +:
                                           sli_pkg::CODE_W]),
        .logic_select(step_settings[(B + sli_pkg::SLOT_LOGIC) * sli_pkg::CODE_W +:
                                    sli_pkg::LOGIC_W]),
        .step_results(results),
        .terminals(digital_input_terminals),
        .forward_run_terminal(forward_run_terminal),
        .reverse_run_terminal(reverse_run_terminal),
        .status_vec(status_vec),
        .result(results[g])
      );
    end
  endgenerate

  // results leave only as observation signals, no code writes them
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      step_results <= '0;
    end else begin
      step_results <= results; // R03
    end
  end
endmodule : sli_engine

// ### core/sli_pkg.sv
// sli_pkg: constants for the ten-step sequence engine.
// assumes selector codes arrive as plain binary numbers (not bcd).
package sli_pkg;
  // ==========================================================
  // structure
  localparam int STEP_COUNT = 10;
  localparam int CODES_PER_STEP = 5;
  localparam int CODE_W = 16;
  localparam int LOGIC_W = 4;
  localparam int TIMER_W = 16;
  localparam int TERM_COUNT = 7;
  // ==========================================================
  // parameter code slots within a step
  localparam int SLOT_IN1 = 0;
  localparam int SLOT_IN2 = 1;
  localparam int SLOT_LOGIC = 2;
  localparam int SLOT_TIMER_SEL = 3;
  localparam int SLOT_TIMER_VAL = 4;
  localparam int FIRST_CODE = 1;
  localparam int LAST_CODE = 50;
  // ==========================================================
  // input selector codes
  localparam logic [CODE_W-1:0] SEL_STEP_FIRST = 16'h07D1;
  localparam logic [CODE_W-1:0] SEL_STEP_LAST = 16'h07DA;
  localparam logic [CODE_W-1:0] SEL_STEP_BASE = 16'h07D0;
  localparam logic [CODE_W-1:0] SEL_TERM_FIRST = 16'h0FA1;
  localparam logic [CODE_W-1:0] SEL_TERM_LAST = 16'h0FA7;
  localparam logic [CODE_W-1:0] SEL_TERM_BASE = 16'h0FA0;
  localparam logic [CODE_W-1:0] SEL_FWD_TERM = 16'h0FAA;
  localparam logic [CODE_W-1:0] SEL_REV_TERM = 16'h0FAB;
  localparam logic [CODE_W-1:0] SEL_STAT_FIRST = 16'h1770;
  localparam logic [CODE_W-1:0] SEL_STAT_LAST = 16'h1777;
  localparam logic [CODE_W-1:0] SEL_INVERT_OFFSET = 16'h03E8;
  // ==========================================================
  // logic circuit codes
  localparam logic [LOGIC_W-1:0] LOGIC_OFF = 4'h0;
  localparam logic [LOGIC_W-1:0] LOGIC_THROUGH = 4'h1;
  localparam logic [LOGIC_W-1:0] LOGIC_AND = 4'h2;
  localparam logic [LOGIC_W-1:0] LOGIC_OR = 4'h3;
  localparam logic [LOGIC_W-1:0] LOGIC_XOR = 4'h4;
  // ==========================================================
  // timing and reset values
  localparam int CLK_MHZ = 100;
  localparam int TICK_MS = 2;
  localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;
  localparam logic [0:0] MODE_ENABLE = 1'h1;
  localparam logic [0:0] RESULT_RESET = 1'h0;
endpackage : sli_pkg

// ### core/sli_step.sv
// sli_step: one step, two selected inputs and a basic gate.
// assumes source vectors are registered upstream; updated on tick, cleared on any cycle while disabled.
`timescale 1ns/1ps
module sli_step (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic enable,
  input wire logic [sli_pkg::CODE_W-1:0] first_input_select,
  input wire logic [sli_pkg::CODE_W-1:0] second_input_select,
  input wire logic [sli_pkg::LOGIC_W-1:0] logic_select,
  input wire logic [sli_pkg::STEP_COUNT-1:0] step_results,
  input wire logic [sli_pkg::TERM_COUNT-1:0] terminals,
  input wire logic forward_run_terminal,
  input wire logic reverse_run_terminal,
  input wire logic [7:0] status_vec,
  output logic result
);
  logic next_result;
  logic a;
  logic b;

  // ==========================================================
  // source multiplexer
  function automatic logic pick(input logic [sli_pkg::CODE_W-1:0] code,
                                input logic [sli_pkg::STEP_COUNT-1:0] st,
                                input logic [sli_pkg::TERM_COUNT-1:0] tm,
                                input logic fw,
                                input logic rv,
                                input logic [7:0] sv);
    logic [sli_pkg::CODE_W-1:0] base;
    logic inv;
    logic v;
    logic [sli_pkg::CODE_W-1:0] idx;
    base = code;
    inv = 1'b0;
    v = 1'b0;
    // odd thousands are the inverted twin of the code below
    if ((code >= sli_pkg::SEL_STEP_FIRST + sli_pkg::SEL_INVERT_OFFSET &&
         code <= sli_pkg::SEL_STEP_LAST + sli_pkg::SEL_INVERT_OFFSET) ||
        (code >= sli_pkg::SEL_TERM_FIRST + sli_pkg::SEL_INVERT_OFFSET &&
         code <= sli_pkg::SEL_REV_TERM + sli_pkg::SEL_INVERT_OFFSET) ||
        (code >= sli_pkg::SEL_STAT_FIRST + sli_pkg::SEL_INVERT_OFFSET &&
         code <= sli_pkg::SEL_STAT_LAST + sli_pkg::SEL_INVERT_OFFSET)) begin // R14
      base = code - sli_pkg::SEL_INVERT_OFFSET;
      inv = 1'b1;
    end
    if (base >= sli_pkg::SEL_STEP_FIRST && base <= sli_pkg::SEL_STEP_LAST) begin // R04
      idx = base - sli_pkg::SEL_STEP_FIRST;
      v = st[idx[3:0]];
    end else if (base >= sli_pkg::SEL_TERM_FIRST && base <= sli_pkg::SEL_TERM_LAST) begin // R05
      idx = base - sli_pkg::SEL_TERM_FIRST;
      v = tm[idx[2:0]];
    end else if (base == sli_pkg::SEL_FWD_TERM) begin // R06
      v = fw;
    end else if (base == sli_pkg::SEL_REV_TERM) begin // R06
      v = rv;
    end else if (base >= sli_pkg::SEL_STAT_FIRST && base <= sli_pkg::SEL_STAT_LAST) begin // R08
      idx = base - sli_pkg::SEL_STAT_FIRST;
      v = sv[idx[2:0]];
    end else begin
      // unlisted codes read as off; their meaning is not defined here
      inv = 1'b0;
    end
    return v ^ inv;
  endfunction : pick

  // ==========================================================
  // logic circuit
  always_comb begin
    a = pick(first_input_select, step_results, terminals,
             forward_run_terminal, reverse_run_terminal, status_vec);
    b = pick(second_input_select, step_results, terminals,
             forward_run_terminal, reverse_run_terminal, status_vec);
    next_result = result;
    if (!enable) begin
      next_result = sli_pkg::RESULT_RESET;
    end else if (tick) begin
      case (logic_select) // R13
        sli_pkg::LOGIC_OFF: next_result = 1'b0;
        sli_pkg::LOGIC_THROUGH: next_result = a;
        sli_pkg::LOGIC_AND: next_result = a & b;
        sli_pkg::LOGIC_OR: next_result = a | b;
        sli_pkg::LOGIC_XOR: next_result = a ^ b;
        default: next_result = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      result <= sli_pkg::RESULT_RESET;
    end else begin
      result <= next_result;
    end
  end
endmodule : sli_step

// ### verification/sli_drive_model.sv
// sli_drive_model: drive control core side of the step engine, status flags only.
// assumes the bench sets drive_state off the rising edge; flags move after it.
`timescale 1ns/1ps
module sli_drive_model (
  input wire logic core_clk,
  input wire logic [8:0] drive_state,
  output logic frequency_command_nonzero,
  output logic run_command,
  output logic forward_command,
  output logic reverse_command,
  output logic accelerating_flag,
  output logic decelerating_flag,
  output logic anti_regen_active_flag,
  output logic dancer_in_range_flag,
  output logic alarm_present
);
  // ==========================================================
  // status levels
  // registered so flags change just after an edge, like the real core
  always_ff @(posedge core_clk) begin
    {frequency_command_nonzero, run_command, forward_command, reverse_command,
     accelerating_flag, decelerating_flag, anti_regen_active_flag,
     dancer_in_range_flag, alarm_present} <= drive_state;
  end
endmodule : sli_drive_model

// ### verification/sli_engine_sva.sv
// sli_engine_sva: port checks of the step engine.
// assumes one clock domain; bound to every sli_engine instance.
`timescale 1ns/1ps
module sli_engine_sva #(
  parameter int TICK_CYCLES = sli_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic sequence_mode_select,
  input wire logic [sli_pkg::LAST_CODE*sli_pkg::CODE_W-1:0] step_settings,
  input wire logic [sli_pkg::TERM_COUNT-1:0] digital_input_terminals,
  input wire logic [sli_pkg::STEP_COUNT-1:0] step_results,
  input wire logic sequence_tick
);
  // ==========================================================
  // helpers
  int gap;
  logic seen;
  wire [15:0] in1 = step_settings[15:0];
  wire [3:0] lg1 = step_settings[35:32];
  always_ff @(posedge core_clk) begin
    gap <= (!nrst || sequence_tick) ? 0 : gap + 1;
    seen <= !nrst ? 1'b0 : (seen || sequence_tick);
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // assertions
  a_tick_pulse: assert property (sequence_tick |=> !sequence_tick)
    else $error("tick longer than one cycle");
  a_tick_period: assert property (sequence_tick && seen |-> gap == TICK_CYCLES-1)
    else $error("tick spacing wrong");
  a_tick_bound: assert property (gap <= TICK_CYCLES)
    else $error("tick missing");
  a_result_cause: assert property (step_results != $past(step_results) |->
    $past(sequence_tick) || $past(sequence_tick, 2) || !$past(sequence_mode_select)
    || !$past(sequence_mode_select, 2)) else $error("results moved without tick");
  a_mode_clear: assert property (!sequence_mode_select [*3] |-> step_results == '0)
    else $error("results not cleared");
  a_reset_vals: assert property (disable iff (1'b0) !nrst |=>
    step_results == '0 && !sequence_tick) else $error("bad reset values");
  for (genvar k = 0; k < sli_pkg::STEP_COUNT; k++) begin : g_off
    a_step_off: assert property (sequence_tick && sequence_mode_select &&
      step_settings[(5*k+2)*16 +: 4] == sli_pkg::LOGIC_OFF |-> ##2 !step_results[k])
      else $error("off step drove high");
  end
  a_thru_term: assert property (sequence_tick && sequence_mode_select && in1 == 16'h0FA1
    && lg1 == 4'h1 |-> ##2 step_results[0] == $past(digital_input_terminals[0], 2))
    else $error("terminal not passed");
  a_inv_term: assert property (sequence_tick && sequence_mode_select && in1 == 16'h1389
    && lg1 == 4'h1 |-> ##2 step_results[0] != $past(digital_input_terminals[0], 2))
    else $error("terminal not inverted");
  c_tick: cover property (sequence_tick);
  c_result: cover property (step_results != '0);
  c_mode_off: cover property ($fell(sequence_mode_select));
endmodule : sli_engine_sva
bind sli_engine sli_engine_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.core_clk(core_clk), .nrst(nrst),
  .sequence_mode_select(sequence_mode_select), .step_settings(step_settings),
  .digital_input_terminals(digital_input_terminals), .step_results(step_results),
  .sequence_tick(sequence_tick));

// ### verification/test_sli_engine.sv
// test_sli_engine: directed sequence of step setups checked on each tick.
// assumes a shortened tick so the run stays short; the tick logic is unchanged.
`timescale 1ns/1ps
module test_sli_engine;
  // full 2 ms tick would cost 200000 cycles per evaluation
  localparam int SIM_TICK = 200;
  logic core_clk, nrst, mode, fwd_t, rev_t, tick;
  logic fnz, run, fwc, rvc, acc, dec, rga, dan, alm;
  logic [sli_pkg::LAST_CODE*sli_pkg::CODE_W-1:0] cfg;
  logic [6:0] term;
  logic [8:0] ds;
  logic [9:0] res;
  int errors, n_compared;
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  sli_drive_model u_drive (.core_clk(core_clk), .drive_state(ds),
    .frequency_command_nonzero(fnz), .run_command(run), .forward_command(fwc),
    .reverse_command(rvc), .accelerating_flag(acc), .decelerating_flag(dec),
    .anti_regen_active_flag(rga), .dancer_in_range_flag(dan), .alarm_present(alm));
  sli_engine #(.TICK_CYCLES(SIM_TICK)) dut (.core_clk(core_clk), .nrst(nrst),
    .sequence_mode_select(mode),
    .step_settings(cfg), .digital_input_terminals(term), .forward_run_terminal(fwd_t),
    .reverse_run_terminal(rev_t), .frequency_command_nonzero(fnz), .run_command(run),
    .forward_command(fwc), .reverse_command(rvc), .accelerating_flag(acc),
    .decelerating_flag(dec), .anti_regen_active_flag(rga), .dancer_in_range_flag(dan),
    .alarm_present(alm), .step_results(res), .sequence_tick(tick));
  // ==========================================================
  // tasks
  task automatic set_step(input int k, input logic [15:0] a, input logic [15:0] b,
    input logic [15:0] l);
    cfg[(5*k-4)*16-1 -: 16] = a;
    cfg[(5*k-3)*16-1 -: 16] = b;
    cfg[(5*k-2)*16-1 -: 16] = l;
  endtask : set_step
  task automatic check(input logic [9:0] exp);
    n_compared++;
    if (res !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, res, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("compared=%0d errors=%0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // bounded wait, then three edges so the registered results have landed
  task automatic wait_tick();
    for (int i = 0; i < SIM_TICK + 100 && tick !== 1'b1; i++)
      @(negedge core_clk);
    if (tick !== 1'b1) begin
      errors++;
      complete_run();
    end
    else repeat (3) @(negedge core_clk);
  endtask : wait_tick
  // ==========================================================
  // sequence
  initial begin
    errors = 0;
    n_compared = 0;
    nrst = 1'b0;
    mode = 1'b1;
    cfg = '0;
    term = 7'h41;
    fwd_t = 1'b1;
    rev_t = 1'b0;
    ds = 9'h1BB;
    repeat (6) @(negedge core_clk);
    nrst = 1'b1;
    set_step(1, 16'h0FA1, 16'h0000, 16'h0001);
    set_step(2, 16'h0FA7, 16'h0FAA, 16'h0002);
    set_step(3, 16'h0FAB, 16'h1393, 16'h0003);
    set_step(4, 16'h1770, 16'h1771, 16'h0004);
    set_step(5, 16'h1772, 16'h1B5A, 16'h0002);
    set_step(6, 16'h1773, 16'h1774, 16'h0002);
    set_step(7, 16'h1775, 16'h1776, 16'h0003);
    set_step(8, 16'h1777, 16'h0000, 16'h0001);
    set_step(9, 16'h07D1, 16'h0000, 16'h0001);
    set_step(10, 16'h0FA1, 16'h0FA1, 16'h0000);
    wait_tick();
    check(10'h06F);
    $display("test sources done");
    set_step(1, 16'h1389, 16'h0000, 16'h0001);
    set_step(10, 16'h0BB9, 16'h0069, 16'h0003);
    ds = 9'h0BA;
    wait_tick();
    check(10'h1E6);
    $display("test feedback done");
    mode = 1'b0;
    repeat (3) @(negedge core_clk);
    check(10'h000);
    $display("test disable done");
    complete_run();
  end
endmodule : test_sli_engine
